//--- logic/fpe_host.sv
// Purpose: host controller issuing program, erase and suspend orders to a serial flash
// Assumes: single ref_clk domain; link clock divided from it; flash samples on rising sck
// Notes:   status polling is done here so software only watches the done bit
module fpe_host (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash link
  output logic             flashSelN,
  output logic             flashSck,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOeN,
  input  wire logic [3:0]  ioIn
);
  typedef struct packed {
    fpe_pkg::fpe_state_type st;
    logic [7:0]  opc;
    logic [23:0] addr;
    logic [31:0] data;
    logic [2:0]  nBytes;
    logic        quadEn;
    logic [5:0]  prot;      // complement, sector, top-bottom, level2..0
    logic        busy;      // engine running
    logic        done;      // sticky: last order finished
    logic        refused;   // sticky: order refused by host checks
    logic        eraseSus;
    logic        progSus;
    logic [7:0]  flashStat;
    logic [15:0] susTimer;  // counts down after resume
    logic [5:0]  bitCnt;    // link clock rising edges left in phase
    logic [2:0]  div;
    logic        sck;
    logic        selN;
    logic [3:0]  dout;
    logic [3:0]  oeN;
    logic [7:0]  shIn;
    logic [31:0] rdata;
    logic        ready;
    logic        slvErr;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
  } fpe_regs_type;

  fpe_regs_type q, d;

  // classify opcodes used more than once
  function automatic logic isErase(input logic [7:0] op);
    isErase = (op == fpe_pkg::OP_SE4K) || (op == fpe_pkg::OP_BE32K) ||
              (op == fpe_pkg::OP_BE64K) || (op == fpe_pkg::OP_CE1) ||
              (op == fpe_pkg::OP_CE2);
  endfunction : isErase

  function automatic logic isProg(input logic [7:0] op);
    isProg = (op == fpe_pkg::OP_QPP) || (op == fpe_pkg::OP_PP);
  endfunction : isProg

  function automatic logic isWrsr(input logic [7:0] op);
    isWrsr = (op == fpe_pkg::OP_WRSR1) || (op == fpe_pkg::OP_WRSR2);
  endfunction : isWrsr

  logic       wrAcc;
  logic       legal;
  logic       quadPhase;
  logic       sckFall;
  logic       sckRise;
  logic [5:0] phaseBits;
  logic [7:0] statNow;

  always_comb begin
    d         = q;
    // a write lands only on the edge that sees pready high
    wrAcc     = psel && penable && pwrite && q.ready;
    quadPhase = (q.opc == fpe_pkg::OP_QPP) && (q.st == fpe_pkg::S_ADDR ||
                q.st == fpe_pkg::S_DATA);
    sckFall   = (q.div == fpe_pkg::SCK_HALF) && q.sck;
    sckRise   = (q.div == fpe_pkg::SCK_HALF) && !q.sck;
    phaseBits = 6'h00;
    statNow   = {q.flashStat[6:0], q.sync2[1]};
    // host-side screen of orders the flash would refuse or forbid
    legal = 1'b1;
    if (q.opc == fpe_pkg::OP_QPP && !q.quadEn) legal = 1'b0;
    if (q.eraseSus && (isErase(q.opc) || isWrsr(q.opc))) legal = 1'b0;
    if (q.progSus && (isErase(q.opc) || isProg(q.opc) || isWrsr(q.opc)))
      legal = 1'b0;
    if (q.opc == fpe_pkg::OP_SUSP &&
        (q.eraseSus || q.progSus || q.susTimer != 16'h0000)) legal = 1'b0;
    if (q.opc == fpe_pkg::OP_RESUME && !(q.eraseSus || q.progSus)) legal = 1'b0;
    if ((q.opc == fpe_pkg::OP_CE1 || q.opc == fpe_pkg::OP_CE2) && q.prot[2:0] != 3'h0)
      legal = 1'b0;

    // two-flop sync of data lanes
    d.sync1 = ioIn;
    d.sync2 = q.sync1;
    if (q.susTimer != 16'h0000) d.susTimer = q.susTimer - 16'h0001;

    // apb slave, one wait state then ready
    d.ready  = psel && penable && !q.ready;
    d.slvErr = 1'b0;
    if (psel && penable && !q.ready) begin
      unique case (paddr)
        fpe_pkg::REG_CTRL: d.rdata = {21'h000000, q.nBytes, q.opc};
        fpe_pkg::REG_ADDR: d.rdata = {8'h00, q.addr};
        fpe_pkg::REG_DATA: d.rdata = q.data;
        fpe_pkg::REG_STAT: d.rdata = {16'h0000, q.flashStat, 3'h0,
                                      q.progSus, q.eraseSus, q.refused, q.done, q.busy};
        fpe_pkg::REG_CFG:  d.rdata = {25'h0000000, q.prot, q.quadEn};
        default: begin
          d.rdata  = fpe_pkg::RESET_VAL;
          d.slvErr = 1'b1;
        end
      endcase
    end
    if (wrAcc && !q.busy) begin
      case (paddr)
        fpe_pkg::REG_ADDR: d.addr = pwdata[23:0];
        fpe_pkg::REG_DATA: d.data = pwdata;
        fpe_pkg::REG_CFG: begin
          d.quadEn = pwdata[0];
          d.prot   = pwdata[6:1];
        end
        fpe_pkg::REG_CTRL: begin
          d.opc    = pwdata[7:0];
          d.nBytes = (pwdata[10:8] > fpe_pkg::MAX_BYTES) ? fpe_pkg::MAX_BYTES : pwdata[10:8];
          if (pwdata[31]) begin
            d.busy = 1'b1;
            d.st   = fpe_pkg::S_WAIT; // screen next cycle once opcode settles
          end
        end
        default: ; // unmapped already flagged with pslverr, status clears below
      endcase
    end

    // link clock divider, running only inside a frame
    if (q.st != fpe_pkg::S_IDLE && q.st != fpe_pkg::S_WAIT && !q.selN) begin
      d.div = (q.div == fpe_pkg::SCK_HALF) ? 3'h0 : q.div + 3'h1;
      if (q.div == fpe_pkg::SCK_HALF) d.sck = !q.sck;
    end else begin
      d.div = 3'h0;
      d.sck = 1'b0;
    end

    unique case (q.st)
      fpe_pkg::S_IDLE: ;
      fpe_pkg::S_WAIT: begin
        if (!legal) begin
          d.refused = 1'b1;
          d.done    = 1'b1;
          d.busy    = 1'b0;
          d.st      = fpe_pkg::S_IDLE;
        end else if (isErase(q.opc) || isProg(q.opc)) begin
          // a refused order must never pull select low
          d.st     = fpe_pkg::S_WREN;
          d.selN   = 1'b0;
          d.bitCnt = 6'd8;
          d.dout   = {3'h0, fpe_pkg::OP_WREN[7]};
          d.oeN    = 4'hE;
          d.shIn   = fpe_pkg::OP_WREN;
        end else begin
          d.st = fpe_pkg::S_GAP;
        end
      end
      // write enable frame: one byte, single lane
      fpe_pkg::S_WREN: begin
        if (sckFall) begin
          d.shIn = {q.shIn[6:0], 1'b0};
          d.dout = {3'h0, q.shIn[6]};
        end
        if (sckRise) d.bitCnt = q.bitCnt - 6'd1;
        // select rises on the fall after the eighth bit so the latch gets set
        if (q.bitCnt == 6'd0 && sckFall) begin
          d.selN = 1'b1;
          d.oeN  = 4'hF;
          d.st   = fpe_pkg::S_GAP;
        end
      end
      // deselect gap, then opcode frame
      fpe_pkg::S_GAP: begin
        d.selN   = 1'b0;
        d.st     = fpe_pkg::S_OPC;
        d.bitCnt = 6'd8;
        d.shIn   = {q.opc[6:0], 1'b0};
        d.dout   = {3'h0, q.opc[7]};
        d.oeN    = 4'hE;
      end
      fpe_pkg::S_OPC: begin
        if (sckRise) begin
          d.bitCnt = q.bitCnt - 6'd1;
          if (q.bitCnt == 6'd1) begin
            if (q.opc == fpe_pkg::OP_CE1 || q.opc == fpe_pkg::OP_CE2 ||
                q.opc == fpe_pkg::OP_SUSP || q.opc == fpe_pkg::OP_RESUME) begin
              d.st = fpe_pkg::S_END;
              if (q.opc == fpe_pkg::OP_RESUME)
                d.susTimer = 16'(fpe_pkg::SUSPEND_LAT_CYC);
            end
          end
        end
        if (sckFall) begin
          d.shIn = {q.shIn[6:0], 1'b0};
          d.dout = {3'h0, q.shIn[7]};
          if (q.bitCnt == 6'd0) d.dout = 4'h0;
        end
        // address phase starts on the fall after the last opcode bit
        if (q.st == fpe_pkg::S_OPC && q.bitCnt == 6'd0 && sckFall) begin
          d.st      = fpe_pkg::S_ADDR;
          phaseBits = (q.opc == fpe_pkg::OP_QPP) ? 6'd6 : 6'd24;
          d.bitCnt  = phaseBits;
          d.oeN     = (q.opc == fpe_pkg::OP_QPP) ? 4'h0 : 4'hE;
          d.dout    = (q.opc == fpe_pkg::OP_QPP) ? q.addr[23:20] : {3'h0, q.addr[23]};
          d.addr    = (q.opc == fpe_pkg::OP_QPP) ? {q.addr[19:0], q.addr[23:20]}
                                                 : {q.addr[22:0], q.addr[23]};
        end
      end
      // address, then data, shifted msb first
      fpe_pkg::S_ADDR, fpe_pkg::S_DATA: begin
        if (sckRise && q.bitCnt != 6'd0) d.bitCnt = q.bitCnt - 6'd1;
        if (sckFall && q.bitCnt != 6'd0) begin
          d.dout = quadPhase ? q.addr[23:20] : {3'h0, q.addr[23]};
          d.addr = quadPhase ? {q.addr[19:0], q.addr[23:20]} : {q.addr[22:0], q.addr[23]};
          if (q.st == fpe_pkg::S_DATA) begin
            d.dout = quadPhase ? q.data[31:28] : {3'h0, q.data[31]};
            d.data = quadPhase ? {q.data[27:0], q.data[31:28]} : {q.data[30:0], q.data[31]};
            d.addr = q.addr;
          end
        end
        if (sckFall && q.bitCnt == 6'd0) begin
          if (q.st == fpe_pkg::S_ADDR && isProg(q.opc) && q.nBytes != 3'h0) begin
            d.st     = fpe_pkg::S_DATA;
            d.bitCnt = quadPhase ? {2'h0, q.nBytes, 1'b0} : {q.nBytes, 3'h0};
            d.dout   = quadPhase ? q.data[31:28] : {3'h0, q.data[31]};
            d.data   = quadPhase ? {q.data[27:0], q.data[31:28]} : {q.data[30:0], q.data[31]};
          end else begin
            d.selN = 1'b1;
            d.oeN  = 4'hF;
            d.st   = fpe_pkg::S_POLL;
          end
        end
      end
      // select rises on the byte boundary right after the last bit
      fpe_pkg::S_END: begin
        d.selN = 1'b1;
        d.oeN  = 4'hF;
        if (q.opc == fpe_pkg::OP_SUSP) d.eraseSus = 1'b1;
        if (q.opc == fpe_pkg::OP_RESUME) begin
          d.eraseSus = 1'b0;
          d.progSus  = 1'b0;
        end
        d.st = fpe_pkg::S_POLL;
      end
      // status poll until busy reads zero or the suspend bit reads one
      fpe_pkg::S_POLL: begin
        d.selN   = 1'b0;
        d.oeN    = 4'hE;
        d.st     = fpe_pkg::S_PREAD;
        d.bitCnt = 6'd16;
        d.shIn   = fpe_pkg::OP_RDSR;
        d.dout   = {3'h0, fpe_pkg::OP_RDSR[7]};
      end
      fpe_pkg::S_PREAD: begin
        if (sckFall && q.bitCnt > 6'd8) begin
          d.shIn = {q.shIn[6:0], 1'b0};
          d.dout = {3'h0, q.shIn[6]};
        end
        if (sckFall && q.bitCnt == 6'd8) d.oeN = 4'hF;
        if (sckRise) d.bitCnt = q.bitCnt - 6'd1;
        // synchroniser lags two cycles: a bit shifted out on one fall is taken on the next
        if (sckFall && q.bitCnt < 6'd8) d.flashStat = statNow;
        if (sckFall && q.bitCnt == 6'd0) begin
          d.selN = 1'b1;
          if (!statNow[fpe_pkg::BUSY_BIT] || statNow[fpe_pkg::SUS_BIT]) begin
            d.st   = fpe_pkg::S_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
            if (q.opc == fpe_pkg::OP_SUSP && !statNow[fpe_pkg::SUS_BIT])
              d.eraseSus = 1'b0;
            if (q.opc == fpe_pkg::OP_SUSP && statNow[fpe_pkg::SUS_BIT])
              d.refused = 1'b0;
          end else begin
            d.st = fpe_pkg::S_POLL;
          end
        end
      end
      default: d.st = fpe_pkg::S_IDLE;
    endcase
    // clear sticky flags on status write; a finish in the same cycle wins
    if (wrAcc && paddr == fpe_pkg::REG_STAT) begin
      if (pwdata[1] && !(d.done && !q.done)) d.done = 1'b0;
      if (pwdata[2] && !(d.refused && !q.refused)) d.refused = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q      <= '0;
      q.selN <= 1'b1;
      q.oeN  <= 4'hF;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign prdata    = q.rdata;
  assign pready    = q.ready;
  assign pslverr   = q.slvErr;
  assign flashSelN = q.selN;
  assign flashSck  = q.sck;
  assign ioOut     = q.dout;
  assign ioOeN     = q.oeN;

  // assertions
  selHigh_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (q.st == fpe_pkg::S_IDLE) |-> flashSelN) else $error("select low while idle");
  quadNeedsEn_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (q.st == fpe_pkg::S_ADDR && q.opc == fpe_pkg::OP_QPP) |-> q.quadEn)
    else $error("quad program without quad lanes");
  quadLanes_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (q.st == fpe_pkg::S_DATA && q.opc == fpe_pkg::OP_QPP) |-> (ioOeN == 4'h0))
    else $error("quad data not on four lanes");
  wrenFirst_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (q.st == fpe_pkg::S_WAIT && legal && isErase(q.opc)) |=> (q.st == fpe_pkg::S_WREN))
    else $error("erase without write enable");
  eraseSusBlock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (q.st == fpe_pkg::S_WAIT && q.eraseSus && isErase(q.opc)) |=> q.refused)
    else $error("erase issued during erase suspend");
  progSusBlock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (q.st == fpe_pkg::S_WAIT && q.progSus && isProg(q.opc)) |=> q.refused)
    else $error("program issued during program suspend");
  susGap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (q.st == fpe_pkg::S_OPC && q.opc == fpe_pkg::OP_SUSP) |-> (q.susTimer == 16'h0000))
    else $error("suspend too soon after resume");
  pollDone_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(q.busy) && !q.refused |-> (q.st == fpe_pkg::S_IDLE))
    else $error("engine left busy early");
  apbReady_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && penable && !pready) |=> pready) else $error("apb answer late");

  eraseRun_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    q.st == fpe_pkg::S_POLL && isErase(q.opc));
  quadRun_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    q.st == fpe_pkg::S_DATA && q.opc == fpe_pkg::OP_QPP);
  suspend_c: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(q.eraseSus));
endmodule : fpe_host

//--- logic/fpe_pkg.sv
// Purpose: constants for the flash program/erase host controller
// Assumes: 10 MHz ref_clk, APB register slave, serial flash on a 4-lane link
// Notes:   link clock is made in fpe_host by dividing ref_clk; SCK_HALF here sets the ratio
package fpe_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00; // go, opcode, data count
  localparam logic [7:0] REG_ADDR   = 8'h04; // 24-bit flash address
  localparam logic [7:0] REG_DATA   = 8'h08; // 32-bit program data word
  localparam logic [7:0] REG_STAT   = 8'h0C; // engine and flash status
  localparam logic [7:0] REG_CFG    = 8'h10; // quad lane enable, protect bits
  // opcodes
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_RDSR    = 8'h05;
  localparam logic [7:0] OP_QPP     = 8'h33;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_SE4K    = 8'h20;
  localparam logic [7:0] OP_BE32K   = 8'h52;
  localparam logic [7:0] OP_BE64K   = 8'hD8;
  localparam logic [7:0] OP_CE1     = 8'hC7;
  localparam logic [7:0] OP_CE2     = 8'h60;
  localparam logic [7:0] OP_SUSP    = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7A;
  localparam logic [7:0] OP_WRSR1   = 8'h01;
  localparam logic [7:0] OP_WRSR2   = 8'h31;
  // status bit positions on the flash
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT  = 1;
  localparam int SUS_BIT  = 7;
  // timing
  localparam int CLK_NS          = 100;
  localparam int SUSPEND_LAT_NS  = 20000; // suspend latency, least gap resume to suspend
  localparam int SUSPEND_LAT_CYC = (SUSPEND_LAT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] SCK_HALF = 3'h1; // ref cycles per half link clock minus one
  localparam logic [2:0] MAX_BYTES = 3'h4; // program bytes per order
  localparam logic [31:0] RESET_VAL = 32'h00000000;
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_WREN  = 4'b0001,
    S_GAP   = 4'b0010,
    S_OPC   = 4'b0011,
    S_ADDR  = 4'b0100,
    S_DATA  = 4'b0101,
    S_END   = 4'b0110,
    S_POLL  = 4'b0111,
    S_PREAD = 4'b1000,
    S_WAIT  = 4'b1001
  } fpe_state_type;
endpackage : fpe_pkg

//--- tb/fpe_flash_model.sv
// Purpose: behavioural serial flash as seen from the link pins
// Assumes: samples lanes on rising sck, shifts status out on falling sck
// Notes:   self-timed work shortened to OP_CYC ref cycles to keep runs short
module fpe_flash_model #(
  parameter int OP_CYC  = 300, // program or erase length in ref cycles
  parameter int SUS_CYC = 10   // suspend settling, well inside the latency
) (
  // clock
  input  wire logic       ref_clk,
  // link
  input  wire logic       flashSelN,
  input  wire logic       flashSck,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOeN,
  output logic      [3:0] ioIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  op, lastOp, sr;
  logic [23:0] adr, lastAddr;
  logic [31:0] dat, lastData;
  logic        busy = 1'b0, write_enable_latch = 1'b0, suspend_flag = 1'b0, chipOp = 1'b0, soBit = 1'b0, tog = 1'b0;
  int          nb = 0, tmr = 0, frames = 0, violations = 0;
  time         resumeAt = 0;
  assign sr = {suspend_flag, 5'h00, write_enable_latch, busy};
  // undriven lanes 0, 2 and 3 toggle so a stale value never passes; undriven lane 1 carries the status bit
  assign ioIn = {ioOeN[3] ? tog : ioOut[3], ioOeN[2] ? tog : ioOut[2],
                 ioOeN[1] ? soBit : ioOut[1], ioOeN[0] ? tog : ioOut[0]};
  // self-timed operation countdown
  always @(posedge ref_clk) begin
    tog <= ~tog;
    if (tmr > 0) begin
      tmr <= tmr - 1;
      if (tmr == 1) busy <= 1'b0;
    end
  end
  // new frame
  always @(negedge flashSelN) begin
    nb = 0;
    op = 8'h00;
    adr = 24'h000000;
    dat = 32'h00000000;
  end
  // four lanes after a quad program opcode, one otherwise
  always @(posedge flashSck) begin : capture
    int w;
    logic b;
    w = (op == 8'h33 && nb >= 8) ? 4 : 1;
    for (int i = 0; i < w; i++) begin
      b = (w == 4) ? ioIn[3-i] : ioIn[0];
      if (nb < 8) op = {op[6:0], b};
      else if (nb < 32) adr = {adr[22:0], b};
      else dat = {dat[30:0], b};
      nb++;
    end
  end
  // status shifted out msb first
  always @(negedge flashSck)
    if (!flashSelN && op == 8'h05 && nb >= 8) soBit = sr[7 - ((nb - 8) % 8)];
  // decode on select rise
  always @(posedge flashSelN) begin : decode
    logic pe, er, okLen;
    soBit = ~soBit;
    if (nb == 0) disable decode; // select edge out of reset carries no frame
    er = op inside {8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    pe = er || op inside {8'h02, 8'h33};
    okLen = (op inside {8'h20, 8'h52, 8'hD8}) ? nb == 32 :
            (op inside {8'h02, 8'h33}) ? (nb >= 40 && nb % 8 == 0) :
            (op == 8'h05) ? (nb >= 16 && nb % 8 == 0) : nb == 8;
    if (!okLen) violations++;
    if (pe && busy) violations++;
    if (er && suspend_flag) violations++;
    if (pe && !write_enable_latch) violations++;
    if (op == 8'h06 && okLen) write_enable_latch = 1'b1;
    if (pe && okLen && write_enable_latch && !busy) begin
      busy = 1'b1;
      write_enable_latch = 1'b0;
      tmr = OP_CYC;
      chipOp = op inside {8'hC7, 8'h60};
    end
    if (op == 8'h75 && okLen && busy && !suspend_flag && !chipOp) begin
      if ($time - resumeAt < fpe_pkg::SUSPEND_LAT_NS) violations++;
      suspend_flag = 1'b1;
      tmr = SUS_CYC;
    end
    if (op == 8'h7A && okLen && suspend_flag && !busy) begin
      suspend_flag = 1'b0;
      busy = 1'b1;
      tmr = OP_CYC;
      resumeAt = $time;
    end
    if (op != 8'h05 && op != 8'h06) begin
      frames++;
      lastOp = op;
      lastAddr = adr;
      lastData = dat;
    end
  end
endmodule : fpe_flash_model

//--- tb/tb_top.sv
// Purpose: self-checking bench for the flash program/erase host
// Assumes: flash model on the link, APB master tasks below
// Notes:   row table covers plain orders, hand tests the awkward ones
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [2:0]  nBytes;
    logic [31:0] data;
    logic [6:0]  cfg;
    logic        refused;
    logic [31:0] expData;
  } fpe_row_type;
  logic        ref_clk = 1'b0, sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic        pready, pslverr, flashSelN, flashSck, er;
  logic [3:0]  ioOut, ioOeN, ioIn;
  int          errors = 0, checks = 0, f0;
  fpe_row_type rows [11];
  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;
  fpe_host DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flashSelN(flashSelN), .flashSck(flashSck), .ioOut(ioOut),
    .ioOeN(ioOeN), .ioIn(ioIn));
  fpe_flash_model model (.ref_clk(ref_clk), .flashSelN(flashSelN), .flashSck(flashSck),
    .ioOut(ioOut), .ioOeN(ioOeN), .ioIn(ioIn));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) chk("pready wait", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // host polls the flash; software only waits for done
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, fpe_pkg::REG_STAT, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 3000);
    if (n >= 3000) chk("done wait", 32'h1, 32'h0);
  endtask : wait_done
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // hang guard, far beyond the expected 0.5 ms of traffic
  initial begin
    #5_000_000;
    errors++;
    final_report();
  end
  initial begin
    rows[0]  = '{8'h20, 24'h012345, 3'h0, 32'h0, 7'h01, 1'b0, 32'h0};
    rows[1]  = '{8'h52, 24'h018000, 3'h0, 32'h0, 7'h01, 1'b0, 32'h0};
    rows[2]  = '{8'hD8, 24'h7F0000, 3'h0, 32'h0, 7'h01, 1'b0, 32'h0};
    rows[3]  = '{8'hC7, 24'h000000, 3'h0, 32'h0, 7'h01, 1'b0, 32'h0};
    rows[4]  = '{8'h60, 24'h000000, 3'h0, 32'h0, 7'h00, 1'b0, 32'h0};
    rows[5]  = '{8'h33, 24'h000100, 3'h4, 32'hA1B2C3D4, 7'h01, 1'b0, 32'hA1B2C3D4};
    rows[6]  = '{8'h02, 24'h0001FE, 3'h2, 32'h5A6B7C8D, 7'h00, 1'b0, 32'h00005A6B};
    rows[7]  = '{8'h33, 24'h000100, 3'h4, 32'hA1B2C3D4, 7'h00, 1'b1, 32'h0};
    rows[8]  = '{8'hC7, 24'h000000, 3'h0, 32'h0, 7'h02, 1'b1, 32'h0};
    rows[9]  = '{8'h75, 24'h000000, 3'h0, 32'h0, 7'h01, 1'b0, 32'h0};
    // resume with nothing suspended is screened by the host
    rows[10] = '{8'h7A, 24'h000000, 3'h0, 32'h0, 7'h01, 1'b1, 32'h0};
    repeat (4) @(posedge ref_clk);
    chk("reset pins", 32'h0000002F, {26'h0, flashSelN, flashSck, ioOeN});
    chk("reset pready", 32'h0, {31'h0, pready});
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, fpe_pkg::REG_STAT, 32'h0);
    chk("reset status", 32'h0, rd);
    $display("reset test done");
    foreach (rows[k]) begin
      f0 = model.frames;
      apb(1'b1, fpe_pkg::REG_CFG, {25'h0, rows[k].cfg});
      apb(1'b1, fpe_pkg::REG_ADDR, {8'h00, rows[k].addr});
      apb(1'b1, fpe_pkg::REG_DATA, rows[k].data);
      apb(1'b1, fpe_pkg::REG_CTRL, {1'b1, 20'h00000, rows[k].nBytes, rows[k].op});
      wait_done();
      chk("status", {29'h0, rows[k].refused, 2'h2}, rd & 32'h00000307);
      if (rows[k].refused) chk("frames", 32'(f0), 32'(model.frames));
      else begin
        chk("opcode", {24'h0, rows[k].op}, {24'h0, model.lastOp});
        chk("address", {8'h0, rows[k].addr}, {8'h0, model.lastAddr});
        chk("data", rows[k].expData, model.lastData);
      end
      chk("suspend flag", 32'h0, {31'h0, model.suspend_flag});
      chk("violations", 32'h0, 32'(model.violations));
      chk("link idle", 32'h2, {30'h0, flashSelN, flashSck});
      apb(1'b1, fpe_pkg::REG_STAT, 32'h00000006);
      $display("row %0d test done", k);
    end
    // address write during a running erase is ignored
    apb(1'b1, fpe_pkg::REG_ADDR, 32'h00012000);
    apb(1'b1, fpe_pkg::REG_CTRL, 32'h80000020);
    apb(1'b1, fpe_pkg::REG_ADDR, 32'h000F0000);
    wait_done();
    chk("busy address", 32'h00012000, {8'h0, model.lastAddr});
    chk("violations", 32'h0, 32'(model.violations));
    $display("busy write test done");
    // unmapped address answers with an error
    apb(1'b0, 8'h20, 32'h0);
    chk("slave error", 32'h1, {31'h0, er});
    apb(1'b0, fpe_pkg::REG_ADDR, 32'h0);
    chk("no error", 32'h0, {31'h0, er});
    $display("unmapped test done");
    final_report();
  end
endmodule : tb_top
